// File: pspc_top.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - level mode: paper status follows true input
// - edge mode: paper status holds until read
// - stop option off: scanning bit unaffected
// - stop option on: trip ends scan after lines
// - aux1 direction: 0 input, 1 output
// - aux1 polarity chooses low or high true
// - aux1 level mode: status follows true pin
// - aux1 edge mode: status latches until read
// - aux1 output drives its state bit level
// - aux2 direction: 0 input, 1 output
// - aux2 polarity chooses low or high true
// - aux2 level mode: status follows true pin
// - aux2 edge mode: status latches until read
// - aux2 output drives its state bit level
module pspc_top #(
   parameter int line_count_width = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic paper_detect_in,
   input wire logic line_done,
   input wire logic aux1_in,
   output logic aux1_out,
   output logic aux1_oe,
   input wire logic aux2_in,
   output logic aux2_out,
   output logic aux2_oe,
   output logic scanning,
   output logic irq
);
   typedef struct packed {
      logic [7:0] paper_cfg;
      logic [7:0] aux_cfg;
      logic [line_count_width-1:0] line_target;
      logic [line_count_width-1:0] line_left;
      logic [pspc_pkg::ev_count-1:0] int_status;
      logic [pspc_pkg::ev_count-1:0] int_enable;
      logic [31:0] rdata;
      logic slverr;
      logic wait_done;
      pspc_pkg::pspc_scan_state_type scan_state;
      pspc_pkg::pspc_pin_drive_type aux1_drive;
      pspc_pkg::pspc_pin_drive_type aux2_drive;
   } pspc_top_state_type;

   pspc_top_state_type state;
   pspc_top_state_type next_state;
   pspc_pkg::pspc_apb_req_type req;

   logic [2:0] pins_sync;
   logic status_read;
   logic [2:0] cap_state;
   logic [2:0] cap_trip;
   logic [2:0] cap_enable;
   logic [2:0] cap_pol;
   logic [2:0] cap_edge;
   logic access;

   // refused at elaboration: the count register is one bus word at most
   if (line_count_width < 1 || line_count_width > 32) begin : g_bad_width
      $error("line_count_width must be 1 to 32");
   end

   // decode helper: tests access against one register address
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] reg_addr);
      hit = (addr[11:2] == reg_addr[11:2]);
   endfunction

   // decode helper: any register of the map, for the error response
   function automatic logic mapped(input logic [11:0] addr);
      mapped = hit(addr, pspc_pkg::paper_cfg_addr) | hit(addr, pspc_pkg::aux_cfg_addr) |
         hit(addr, pspc_pkg::status_addr) | hit(addr, pspc_pkg::int_enable_addr) |
         hit(addr, pspc_pkg::int_clear_addr) | hit(addr, pspc_pkg::line_count_addr) |
         hit(addr, pspc_pkg::scan_ctrl_addr);
   endfunction

   assign req.pwrite = pwrite;
   assign req.psel = psel;
   assign req.penable = penable;
   assign req.paddr = paddr;
   assign req.pwdata = pwdata;

   // any access phase cycle; pready marks the one that completes
   assign access = req.psel & req.penable;
   assign status_read = access & ~req.pwrite & hit(req.paddr, pspc_pkg::status_addr);

   // pins come from the board, so two flops before any logic
   pspc_sync #(
      .width(3)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({aux2_in, aux1_in, paper_detect_in}),
      .sync_out(pins_sync)
   );

   // capture setup per input: paper, aux1, aux2
   assign cap_enable[0] = 1'b1;
   assign cap_enable[1] = ~state.aux_cfg[pspc_pkg::aux_dir_bit];
   assign cap_enable[2] = ~state.aux_cfg[pspc_pkg::aux_stride + pspc_pkg::aux_dir_bit];
   assign cap_pol[0] = state.paper_cfg[pspc_pkg::paper_pol_bit];
   assign cap_pol[1] = state.aux_cfg[pspc_pkg::aux_pol_bit];
   assign cap_pol[2] = state.aux_cfg[pspc_pkg::aux_stride + pspc_pkg::aux_pol_bit];
   assign cap_edge[0] = state.paper_cfg[pspc_pkg::paper_edge_bit];
   assign cap_edge[1] = state.aux_cfg[pspc_pkg::aux_edge_bit];
   assign cap_edge[2] = state.aux_cfg[pspc_pkg::aux_stride + pspc_pkg::aux_edge_bit];

   // one capture cell per input, each cleared by the status read
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cap
         pspc_capture u_cap (
            .pclk(pclk),
            .presetn(presetn),
            .pin_level(pins_sync[gi]),
            .high_true(cap_pol[gi]),
            .edge_mode(cap_edge[gi]),
            .enable(cap_enable[gi]),
            .read_clear(status_read),
            .state_bit(cap_state[gi]),
            .trip(cap_trip[gi])
         );
      end
   endgenerate

   always_comb begin
      next_state = state;
      // one wait state: pready in the second access cycle
      next_state.wait_done = access & ~state.wait_done;
      // unmapped addresses answer with an error in either direction
      next_state.slverr = access & ~mapped(req.paddr);

      // register writes take effect only at the completing edge
      if (pready && req.pwrite) begin
         if (hit(req.paddr, pspc_pkg::paper_cfg_addr)) begin
            next_state.paper_cfg = req.pwdata[7:0];
         end else if (hit(req.paddr, pspc_pkg::aux_cfg_addr)) begin
            next_state.aux_cfg = req.pwdata[7:0];
         end else if (hit(req.paddr, pspc_pkg::int_enable_addr)) begin
            next_state.int_enable = req.pwdata[pspc_pkg::ev_count-1:0];
         end else if (hit(req.paddr, pspc_pkg::int_clear_addr)) begin
            next_state.int_status = state.int_status & ~req.pwdata[pspc_pkg::ev_count-1:0];
         end else if (hit(req.paddr, pspc_pkg::line_count_addr)) begin
            next_state.line_target = req.pwdata[line_count_width-1:0];
         end else if (hit(req.paddr, pspc_pkg::scan_ctrl_addr)) begin
            // stands in for the command register's scan bit
            if (req.pwdata[0]) begin
               next_state.scan_state = pspc_pkg::pspc_scan_s;
            end else begin
               next_state.scan_state = pspc_pkg::pspc_idle_type_s;
            end
         end
      end

      // read data registered in the access cycle
      next_state.rdata = 32'h0000_0000;
      if (access && !req.pwrite) begin
         if (hit(req.paddr, pspc_pkg::paper_cfg_addr)) begin
            next_state.rdata[7:0] = state.paper_cfg;
         end else if (hit(req.paddr, pspc_pkg::aux_cfg_addr)) begin
            next_state.rdata[7:0] = state.aux_cfg;
         end else if (hit(req.paddr, pspc_pkg::status_addr)) begin
            next_state.rdata[pspc_pkg::st_paper_bit] = cap_state[0];
            next_state.rdata[pspc_pkg::st_aux1_bit] = cap_state[1];
            next_state.rdata[pspc_pkg::st_aux2_bit] = cap_state[2];
            next_state.rdata[pspc_pkg::st_scanning_bit] = (state.scan_state != pspc_pkg::pspc_idle_type_s);
            next_state.rdata[8 +: pspc_pkg::ev_count] = state.int_status;
         end else if (hit(req.paddr, pspc_pkg::int_enable_addr)) begin
            next_state.rdata[pspc_pkg::ev_count-1:0] = state.int_enable;
         end else if (hit(req.paddr, pspc_pkg::int_clear_addr)) begin
            next_state.rdata = 32'h0000_0000; // write-only
         end else if (hit(req.paddr, pspc_pkg::line_count_addr)) begin
            next_state.rdata[line_count_width-1:0] = state.line_target;
         end else if (hit(req.paddr, pspc_pkg::scan_ctrl_addr)) begin
            next_state.rdata[line_count_width-1:0] = state.line_left;
         end
      end

      // scan stop sequencing
      case (state.scan_state)
         pspc_pkg::pspc_idle_type_s: begin
            next_state.line_left = '0;
         end
         pspc_pkg::pspc_scan_s: begin
            // stop option off leaves the scan running
            if (cap_trip[0] && state.paper_cfg[pspc_pkg::paper_stop_bit]) begin
               next_state.line_left = state.line_target;
               if (state.line_target == '0) begin
                  next_state.scan_state = pspc_pkg::pspc_idle_type_s;
               end else begin
                  next_state.scan_state = pspc_pkg::pspc_drain_s;
               end
            end
         end
         pspc_pkg::pspc_drain_s: begin
            // remaining lines counted down, then command cleared
            if (line_done) begin
               next_state.line_left = state.line_left - line_count_width'(1);
               if (state.line_left == line_count_width'(1)) begin
                  next_state.scan_state = pspc_pkg::pspc_idle_type_s;
               end
            end
         end
         default: begin
            next_state.scan_state = pspc_pkg::pspc_idle_type_s;
         end
      endcase

      // sticky events after the clear, so paper and aux sets win; no scan end is set in a cycle that completes a write
      if (cap_trip[0]) begin
         next_state.int_status[pspc_pkg::ev_paper_trip] = 1'b1;
      end
      if (state.scan_state != pspc_pkg::pspc_idle_type_s &&
          next_state.scan_state == pspc_pkg::pspc_idle_type_s && !(pready && req.pwrite)) begin
         next_state.int_status[pspc_pkg::ev_scan_end] = 1'b1;
      end
      if (cap_trip[1]) begin
         next_state.int_status[pspc_pkg::ev_aux1] = 1'b1;
      end
      if (cap_trip[2]) begin
         next_state.int_status[pspc_pkg::ev_aux2] = 1'b1;
      end

      // pin drivers registered so outputs come from flops
      next_state.aux1_drive.oe = next_state.aux_cfg[pspc_pkg::aux_dir_bit];
      next_state.aux1_drive.out = next_state.aux_cfg[pspc_pkg::aux_out_bit];
      next_state.aux2_drive.oe = next_state.aux_cfg[pspc_pkg::aux_stride + pspc_pkg::aux_dir_bit];
      next_state.aux2_drive.out = next_state.aux_cfg[pspc_pkg::aux_stride + pspc_pkg::aux_out_bit];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.paper_cfg <= pspc_pkg::paper_cfg_reset;
         state.aux_cfg <= pspc_pkg::aux_cfg_reset;
         state.line_target <= line_count_width'(pspc_pkg::line_count_reset);
         state.line_left <= '0;
         state.int_status <= '0;
         state.int_enable <= '0;
         state.rdata <= 32'h0000_0000;
         state.slverr <= 1'b0;
         state.wait_done <= 1'b0;
         state.scan_state <= pspc_pkg::pspc_idle_type_s;
         state.aux1_drive <= '0;
         state.aux2_drive <= '0;
      end else begin
         state <= next_state;
      end
   end

   // pready is combinational, data come from flops one cycle later
   // so the slave takes two access cycles on reads; writes too, for one rhythm
   assign pready = access & state.wait_done;
   assign prdata = state.rdata;
   assign pslverr = pready & state.slverr;
   assign aux1_out = state.aux1_drive.out;
   assign aux1_oe = state.aux1_drive.oe;
   assign aux2_out = state.aux2_drive.out;
   assign aux2_oe = state.aux2_drive.oe;
   assign scanning = (state.scan_state != pspc_pkg::pspc_idle_type_s);
   assign irq = |(state.int_status & state.int_enable);
endmodule
`default_nettype wire

// File: pspc_pkg.sv
package pspc_pkg;

   // register byte addresses (printed offsets 0x58/0x59 are not both multiples of four: index*4)
   localparam logic [7:0] paper_cfg_index = 8'h58;
   localparam logic [7:0] aux_cfg_index = 8'h59;
   localparam logic [11:0] paper_cfg_addr = {2'h0, paper_cfg_index, 2'h0};
   localparam logic [11:0] aux_cfg_addr = {2'h0, aux_cfg_index, 2'h0};
   localparam logic [11:0] status_addr = 12'h400;
   localparam logic [11:0] int_enable_addr = 12'h404;
   localparam logic [11:0] int_clear_addr = 12'h408;
   localparam logic [11:0] line_count_addr = 12'h40C;
   localparam logic [11:0] scan_ctrl_addr = 12'h410;

   // paper detect config field positions
   localparam int paper_pol_bit = 3;
   localparam int paper_edge_bit = 4;
   localparam int paper_stop_bit = 5;

   // aux pin config field positions, pin 1 base 0, pin 2 base 4
   localparam int aux_dir_bit = 0;
   localparam int aux_pol_bit = 1;
   localparam int aux_edge_bit = 2;
   localparam int aux_out_bit = 3;
   localparam int aux_stride = 4;

   // status bit positions
   localparam int st_paper_bit = 0;
   localparam int st_aux1_bit = 1;
   localparam int st_aux2_bit = 2;
   localparam int st_scanning_bit = 3;

   // interrupt event positions
   localparam int ev_paper_trip = 0;
   localparam int ev_scan_end = 1;
   localparam int ev_aux1 = 2;
   localparam int ev_aux2 = 3;
   localparam int ev_count = 4;

   // reset values
   localparam logic [7:0] paper_cfg_reset = 8'h00;
   localparam logic [7:0] aux_cfg_reset = 8'h00;
   localparam logic [7:0] line_count_reset = 8'h00;

   typedef enum logic [1:0] {
      pspc_idle_type_s = 2'b00,
      pspc_scan_s = 2'b01,
      pspc_drain_s = 2'b10
   } pspc_scan_state_type;

   typedef struct packed {
      logic pwrite;
      logic psel;
      logic penable;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pspc_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pspc_apb_rsp_type;

   typedef struct packed {
      logic out;
      logic oe;
   } pspc_pin_drive_type;

endpackage

// File: pspc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pspc_sync #(
   parameter int width = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   typedef struct packed {
      logic [width-1:0] meta;
      logic [width-1:0] stable;
   } pspc_sync_state_type;

   pspc_sync_state_type state;
   pspc_sync_state_type next_state;

   // refused at elaboration: an empty vector has no stages
   if (width < 1) begin : g_bad_width
      $error("pspc_sync width must be at least 1");
   end

   // first stage is read only by the second stage
   always_comb begin
      next_state = state;
      next_state.meta = async_in;
      next_state.stable = state.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_out = state.stable;
endmodule
`default_nettype wire

// File: pspc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module pspc_capture (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_level,
   input wire logic high_true,
   input wire logic edge_mode,
   input wire logic enable,
   input wire logic read_clear,
   output logic state_bit,
   output logic trip
);
   typedef struct packed {
      logic latched;
      logic prev_true;
   } pspc_capture_state_type;

   pspc_capture_state_type state;
   pspc_capture_state_type next_state;
   logic is_true;

   // polarity select: high_true 0 means low level is true
   assign is_true = enable & (high_true ? pin_level : ~pin_level);

   // a true level in the read cycle re-arms the latch, set wins over clear
   always_comb begin
      next_state = state;
      next_state.prev_true = is_true;
      if (is_true) begin
         next_state.latched = 1'b1;
      end else if (read_clear) begin
         next_state.latched = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // level mode reports present state, edge mode the latch
   assign state_bit = edge_mode ? state.latched : is_true;
   assign trip = is_true & ~state.prev_true;
endmodule
`default_nettype wire

// File: pspc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pspc_props #(
   parameter int line_count_width = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic aux1_out,
   input wire logic aux1_oe,
   input wire logic aux2_out,
   input wire logic aux2_oe,
   input wire logic scanning,
   input wire logic irq
);
   logic acc, rd, wr_aux, mapped;
   // completed transfer and its kind
   assign acc = psel && penable && pready;
   assign rd = acc && !pwrite;
   assign wr_aux = acc && pwrite && paddr == pspc_pkg::aux_cfg_addr;
   assign mapped = paddr inside {pspc_pkg::paper_cfg_addr, pspc_pkg::aux_cfg_addr, pspc_pkg::status_addr,
      pspc_pkg::int_enable_addr, pspc_pkg::int_clear_addr, pspc_pkg::line_count_addr, pspc_pkg::scan_ctrl_addr};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   err_unmapped_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong for address");
   clear_zero_a: assert property (rd && paddr == pspc_pkg::int_clear_addr |-> prdata == 32'h0)
      else $error("clear register read not zero");
   cfg_upper_a: assert property (rd && paddr == pspc_pkg::paper_cfg_addr |-> prdata[31:8] == 24'h0)
      else $error("config upper bits not zero");
   aux1_drive_a: assert property (wr_aux |=> aux1_oe == $past(pwdata[0]) && (!aux1_oe || aux1_out == $past(pwdata[3])))
      else $error("aux1 drive differs from config");
   aux2_drive_a: assert property (wr_aux |=> aux2_oe == $past(pwdata[4]) && (!aux2_oe || aux2_out == $past(pwdata[7])))
      else $error("aux2 drive differs from config");
   aux_hold_a: assert property (!(psel && penable && pwrite) |=> $stable({aux1_oe, aux1_out, aux2_oe, aux2_out}))
      else $error("aux drive changed without write");
   cover property (irq);
   cover property ($fell(scanning));
   cover property (acc && pslverr);
endmodule
bind pspc_top pspc_props #(.line_count_width(line_count_width)) u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .aux1_out(aux1_out), .aux1_oe(aux1_oe), .aux2_out(aux2_out),
   .aux2_oe(aux2_oe), .scanning(scanning), .irq(irq));
`default_nettype wire

// File: pspc_board.sv
`timescale 1ns/1ps
`default_nettype none
module pspc_board (
   input wire logic paper_lvl,
   input wire logic a1_lvl,
   input wire logic a2_lvl,
   input wire logic aux1_out,
   input wire logic aux1_oe,
   input wire logic aux2_out,
   input wire logic aux2_oe,
   output logic paper_detect_in,
   output logic aux1_in,
   output logic aux2_in,
   output logic a1_wire,
   output logic a2_wire
);
   // board signal yields to the block while the block drives the pin
   assign a1_wire = aux1_oe ? aux1_out : a1_lvl;
   assign a2_wire = aux2_oe ? aux2_out : a2_lvl;
   assign aux1_in = a1_wire;
   assign aux2_in = a2_wire;
   assign paper_detect_in = paper_lvl;
endmodule
`default_nettype wire

// File: test_paper_sensor_aux_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_paper_sensor_aux_pin_control;
   logic pclk, presetn, psel, penable, pwrite, line_done, err, pready, pslverr, paper_detect_in;
   logic aux1_in, aux2_in, aux1_out, aux1_oe, aux2_out, aux2_oe, scanning, irq;
   logic paper_lvl, a1_lvl, a2_lvl, a1_wire, a2_wire;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int fails, comparisons, cycles;
   pspc_top #(.line_count_width(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .paper_detect_in(paper_detect_in), .line_done(line_done), .aux1_in(aux1_in), .aux1_out(aux1_out),
      .aux1_oe(aux1_oe), .aux2_in(aux2_in), .aux2_out(aux2_out), .aux2_oe(aux2_oe), .scanning(scanning), .irq(irq));
   pspc_board board (.paper_lvl(paper_lvl), .a1_lvl(a1_lvl), .a2_lvl(a2_lvl), .aux1_out(aux1_out),
      .aux1_oe(aux1_oe), .aux2_out(aux2_out), .aux2_oe(aux2_oe), .paper_detect_in(paper_detect_in),
      .aux1_in(aux1_in), .aux2_in(aux2_in), .a1_wire(a1_wire), .a2_wire(a2_wire));
   // 25 MHz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // hang guard, well beyond the few hundred cycles the tests need
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end
   task conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready, then one idle cycle
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task st(input int b, input logic e, input string nm);
      apb(1'b0, pspc_pkg::status_addr, 32'h0);
      chk(nm, 32'(e), 32'(rd[b]));
   endtask
   task setpin(input int p, input logic v);
      if (p == 1)
         a2_lvl <= v;
      else
         a1_lvl <= v;
   endtask
   task pulse_line();
      line_done <= 1'b1;
      @(posedge pclk);
      line_done <= 1'b0;
      w(2);
   endtask
   task t_regs();
      apb(1'b0, pspc_pkg::paper_cfg_addr, 32'h0);
      chk("paper cfg reset", 32'h0, rd);
      apb(1'b0, pspc_pkg::aux_cfg_addr, 32'h0);
      chk("aux cfg reset", 32'h0, rd);
      apb(1'b1, pspc_pkg::line_count_addr, 32'hA5);
      apb(1'b0, pspc_pkg::line_count_addr, 32'h0);
      chk("line count", 32'hA5, rd);
      apb(1'b0, 12'h7F0, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      apb(1'b1, 12'h7F0, 32'h0);
      chk("unmapped write error", 32'h1, 32'(err));
      $display("test regs done");
   endtask
   task t_paper();
      paper_lvl <= 1'b0;
      apb(1'b1, pspc_pkg::paper_cfg_addr, 32'h08);
      w(5);
      st(0, 1'b0, "paper level false");
      paper_lvl <= 1'b1;
      w(5);
      st(0, 1'b1, "paper level true");
      apb(1'b1, pspc_pkg::paper_cfg_addr, 32'h00);
      w(5);
      st(0, 1'b0, "paper low true");
      apb(1'b1, pspc_pkg::paper_cfg_addr, 32'h10);
      w(5);
      st(0, 1'b0, "paper edge idle");
      paper_lvl <= 1'b0;
      w(5);
      paper_lvl <= 1'b1;
      w(5);
      st(0, 1'b1, "paper edge held");
      st(0, 1'b0, "paper edge cleared");
      $display("test paper done");
   endtask
   task t_aux_in();
      for (int p = 0; p < 2; p++) begin
         for (int pol = 0; pol < 2; pol++) begin
            setpin(p, pol[0]);
            apb(1'b1, pspc_pkg::aux_cfg_addr, 32'(pol << (4 * p + 1)));
            w(5);
            st(p + 1, 1'b1, "aux level true");
            setpin(p, !pol[0]);
            w(5);
            st(p + 1, 1'b0, "aux level false");
            apb(1'b1, pspc_pkg::aux_cfg_addr, 32'(((pol << 1) | 4) << (4 * p)));
            w(5);
            st(p + 1, 1'b0, "aux edge idle");
            setpin(p, pol[0]);
            w(5);
            setpin(p, !pol[0]);
            w(5);
            st(p + 1, 1'b1, "aux edge held");
            st(p + 1, 1'b0, "aux edge cleared");
         end
      end
      $display("test aux inputs done");
   endtask
   task t_aux_out();
      for (int p = 0; p < 2; p++) begin
         for (int v = 0; v < 2; v++) begin
            setpin(p, !v[0]);
            apb(1'b1, pspc_pkg::aux_cfg_addr, 32'((1 | (v << 3)) << (4 * p)));
            w(2);
            chk("aux oe", 32'h1, 32'(p == 1 ? aux2_oe : aux1_oe));
            chk("aux wire", 32'(v), 32'(p == 1 ? a2_wire : a1_wire));
         end
      end
      apb(1'b1, pspc_pkg::aux_cfg_addr, 32'h0);
      w(2);
      chk("aux oe off", 32'h0, 32'({aux2_oe, aux1_oe}));
      $display("test aux outputs done");
   endtask
   task t_stop();
      paper_lvl <= 1'b0;
      apb(1'b1, pspc_pkg::paper_cfg_addr, 32'h08);
      apb(1'b1, pspc_pkg::int_enable_addr, 32'h2);
      apb(1'b1, pspc_pkg::scan_ctrl_addr, 32'h1);
      paper_lvl <= 1'b1;
      w(6);
      chk("scan kept", 32'h1, 32'(scanning));
      apb(1'b1, pspc_pkg::scan_ctrl_addr, 32'h0);
      paper_lvl <= 1'b0;
      apb(1'b1, pspc_pkg::line_count_addr, 32'h2);
      apb(1'b1, pspc_pkg::paper_cfg_addr, 32'h28);
      apb(1'b1, pspc_pkg::int_clear_addr, 32'hF);
      chk("irq idle", 32'h0, 32'(irq));
      apb(1'b1, pspc_pkg::scan_ctrl_addr, 32'h1);
      paper_lvl <= 1'b1;
      w(6);
      pulse_line();
      chk("scan after one line", 32'h1, 32'(scanning));
      chk("irq masked trip", 32'h0, 32'(irq));
      pulse_line();
      w(1);
      chk("scan stopped", 32'h0, 32'(scanning));
      chk("irq on scan end", 32'h1, 32'(irq));
      st(9, 1'b1, "scan end event");
      apb(1'b1, pspc_pkg::int_clear_addr, 32'h2);
      chk("irq cleared", 32'h0, 32'(irq));
      apb(1'b1, pspc_pkg::line_count_addr, 32'h0);
      paper_lvl <= 1'b0;
      apb(1'b1, pspc_pkg::scan_ctrl_addr, 32'h1);
      chk("scan restarted", 32'h1, 32'(scanning));
      paper_lvl <= 1'b1;
      w(6);
      chk("scan stopped at once", 32'h0, 32'(scanning));
      $display("test stop done");
   endtask
   initial begin
      {presetn, psel, penable, pwrite, line_done, paper_lvl, a1_lvl, a2_lvl} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_paper();
      t_aux_in();
      t_aux_out();
      t_stop();
      conclude();
   end
endmodule
`default_nettype wire
